// ==== core/clock_multiplier_pkg.sv ====
// Purpose: Shared constants for the clock multiplier control block.
// Assumes: 8-bit special-function register bus with address and page.
// Notes:   Field positions and reset values are named here once.
package clock_multiplier_pkg;

  localparam logic [7:0] CTRL_ADDR       = 8'h97;
  localparam logic [7:0] CTRL_PAGE       = 8'h0f;
  localparam logic [7:0] CTRL_RESET      = 8'h00;

  localparam int         ENABLE_BIT      = 7;
  localparam int         INIT_BIT        = 6;
  localparam int         LOCK_BIT        = 5;
  localparam int         SCALE_MSB       = 4;
  localparam int         SCALE_LSB       = 2;
  localparam int         SOURCE_MSB      = 1;
  localparam int         SOURCE_LSB      = 0;

  // Input source codes; bit 1 clear means the oscillator is halved first.
  localparam logic [1:0] SRC_INT_HALF    = 2'h0;
  localparam logic [1:0] SRC_EXT_HALF    = 2'h1;
  localparam logic [1:0] SRC_INT_FULL    = 2'h2;
  localparam logic [1:0] SRC_EXT_FULL    = 2'h3;

  // Scale codes at or above this one keep two pulses of every code pulses.
  localparam logic [2:0] SCALE_FIRST_DIV = 3'h3;
  localparam logic [2:0] PULSES_PER_EDGE = 3'h4;
  localparam logic [2:0] KEEP_PER_GROUP  = 3'h2;

  // Selected input edges counted after initialization before lock is declared.
  localparam int         LOCK_EDGES      = 16;

endpackage

// ==== core/mul_pulse_if.sv ====
// Purpose: Carries configuration and edges from control to pulse generator.
// Assumes: Single clock domain clk_sys.
// Notes:   The generator reports nothing back besides its pulse.
`timescale 1ns/100ps
interface mul_pulse_if;
  logic       run;
  logic       inEdge;
  logic [2:0] scale;
  logic       pulse;

  modport ctrl (output run, output inEdge, output scale, input pulse);
  modport gen  (input run, input inEdge, input scale, output pulse);
endinterface

// ==== core/mul_pulse_gen.sv ====
// Purpose: Emits four fast enable pulses per input edge, thinned by the scale.
// Assumes: Input edges come at least eight clk_sys cycles apart.
// Notes:   Fast pulses fall on every other cycle, so output never exceeds half rate.
`timescale 1ns/100ps
module mul_pulse_gen (
  input  wire logic   clk_sys,
  input  wire logic   rst,
  mul_pulse_if.gen    port
);

  typedef struct packed {
    logic [2:0] burst;
    logic       gap;
    logic [2:0] phase;
    logic       pulse;
  } gen_state_t;

  gen_state_t st;
  gen_state_t next_st;

  assign port.pulse = st.pulse;

  function automatic logic [2:0] group_len(input logic [2:0] code);
    group_len = (code < clock_multiplier_pkg::SCALE_FIRST_DIV) ? 3'h1 : code;
  endfunction

  always_comb begin
    next_st       = st;
    next_st.pulse = 1'b0;
    if (!port.run) begin
      next_st = '0;
    end else begin
      if (port.inEdge) begin
        next_st.burst = clock_multiplier_pkg::PULSES_PER_EDGE; // R6
        next_st.gap   = 1'b0;
      end else if (st.burst != 3'h0) begin
        next_st.gap = ~st.gap;
        if (!st.gap) begin
          next_st.burst = st.burst - 3'h1; // R1
          if (group_len(port.scale) == 3'h1) begin
            next_st.pulse = 1'b1; // R11
          end else begin
            next_st.pulse = (st.phase < clock_multiplier_pkg::KEEP_PER_GROUP); // R14
            next_st.phase = (st.phase + 3'h1 >= group_len(port.scale)) ? 3'h0 : st.phase + 3'h1;
          end
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule

// ==== core/clock_multiplier_control.sv ====
// Purpose: Control register and lock sequencing of the clock multiplier.
// Assumes: Oscillator inputs are asynchronous and slower than clk_sys / 8.
// Notes:   The multiplied clock is delivered as a one-cycle enable pulse.
// Behaviour
// R1: Output averages four times input frequency, times scale factor 1 or 2/3..2/7.
// R2: Input is external oscillator, or internal or external oscillator halved; the code also takes the internal oscillator unhalved (source code 2).
// R3: Software clears register, sets source, then scale, then enable.
// R4: Software waits over 5 us, sets initialize, then polls ready.
// R5: Software makes an external source stable before initializing.
// R6: Slow input yields four fast pulses per rising edge, then idles.
// R7: Software keeps multiplier output between 25 and 50 MHz.
// R8: Bit 7 enables the multiplier; zero disables it.
// R9: Writing one to bit 6 while enabled starts initialization.
// R10: Bit 5 is read-only, one only when locked and stable.
// R11: Scale bits 4:2; codes 000 and 001 mean factor one.
// R12: Register at address 0x97 page 0x0f, resets to zero.
// R13: Source bits 1:0 select internal or external, halved or not.
// R14: Scale code 011 gives a factor of two thirds.
// R15: Ready drops whenever enable is cleared.
`timescale 1ns/100ps
module clock_multiplier_control #(
  parameter int LOCK_EDGES = clock_multiplier_pkg::LOCK_EDGES
) (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       intOsc,
  input  wire logic       extOsc,
  input  wire logic [7:0] sfrAddr,
  input  wire logic [7:0] sfrPage,
  input  wire logic       sfrWrite,
  input  wire logic [7:0] sfrWdata,
  output logic      [7:0] sfrRdata,
  output logic            mulClkEn,
  output logic            multiplierReady
);

  typedef struct packed {
    logic [1:0] intSync;
    logic [1:0] extSync;
    logic       srcLast;
    logic       halfTog;
    logic       enable;
    logic       init;
    logic       locking;
    logic       ready;
    logic [2:0] scale;
    logic [1:0] source;
    logic [7:0] lockCnt;
    logic       edgeOut;
    logic [7:0] rdata;
    logic       clkEn;
    logic       readyOut;
  } ctrl_state_t;

  ctrl_state_t st;
  ctrl_state_t next_st;
  mul_pulse_if pulses ();

  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] page);
    reg_hit = (addr == clock_multiplier_pkg::CTRL_ADDR) && (page == clock_multiplier_pkg::CTRL_PAGE);
  endfunction

  function automatic logic [7:0] ctrl_value(input ctrl_state_t s);
    ctrl_value = '0;
    ctrl_value[clock_multiplier_pkg::ENABLE_BIT] = s.enable;
    ctrl_value[clock_multiplier_pkg::INIT_BIT]   = s.init;
    ctrl_value[clock_multiplier_pkg::LOCK_BIT]   = s.ready;
    ctrl_value[clock_multiplier_pkg::SCALE_MSB:clock_multiplier_pkg::SCALE_LSB]   = s.scale;
    ctrl_value[clock_multiplier_pkg::SOURCE_MSB:clock_multiplier_pkg::SOURCE_LSB] = s.source;
  endfunction

  logic selLevel;
  logic riseNow;
  logic wrHit;

  always_comb begin
    selLevel = st.source[0] ? st.extSync[1] : st.intSync[1]; // R2
    riseNow  = selLevel && !st.srcLast;
    wrHit    = sfrWrite && reg_hit(sfrAddr, sfrPage);

    next_st         = st;
    next_st.intSync = {st.intSync[0], intOsc};
    next_st.extSync = {st.extSync[0], extOsc};
    next_st.srcLast = selLevel;
    next_st.edgeOut = 1'b0;

    // Halved sources pass every second rising edge; full sources pass all.
    if (riseNow) begin
      next_st.halfTog = ~st.halfTog;
      next_st.edgeOut = st.source[1] || st.halfTog; // R13
    end

    if (st.locking && st.edgeOut) begin
      if (st.lockCnt == 8'(LOCK_EDGES - 1)) begin
        next_st.locking = 1'b0;
        next_st.ready   = 1'b1; // R10
      end else begin
        next_st.lockCnt = st.lockCnt + 8'h01;
      end
    end

    if (wrHit) begin
      next_st.enable = sfrWdata[clock_multiplier_pkg::ENABLE_BIT]; // R8
      next_st.init   = sfrWdata[clock_multiplier_pkg::INIT_BIT];
      next_st.scale  = sfrWdata[clock_multiplier_pkg::SCALE_MSB:clock_multiplier_pkg::SCALE_LSB];
      next_st.source = sfrWdata[clock_multiplier_pkg::SOURCE_MSB:clock_multiplier_pkg::SOURCE_LSB];
      if (st.enable && sfrWdata[clock_multiplier_pkg::ENABLE_BIT] && sfrWdata[clock_multiplier_pkg::INIT_BIT]) begin
        next_st.locking = 1'b1; // R9
        next_st.ready   = 1'b0;
        next_st.lockCnt = '0;
      end
      if (!sfrWdata[clock_multiplier_pkg::ENABLE_BIT]) begin
        next_st.locking = 1'b0; // R15
        next_st.ready   = 1'b0; // R15
        next_st.lockCnt = '0;
      end
    end

    next_st.rdata    = reg_hit(sfrAddr, sfrPage) ? ctrl_value(st) : 8'h00;
    next_st.clkEn    = pulses.pulse;
    next_st.readyOut = next_st.ready;
  end

  assign pulses.run    = st.enable && st.ready;
  assign pulses.inEdge = st.edgeOut;
  assign pulses.scale  = st.scale;

  mul_pulse_gen u_gen (
    .clk_sys (clk_sys),
    .rst     (rst),
    .port    (pulses.gen)
  );

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st <= '0; // R12
    end else begin
      st <= next_st;
    end
  end

  assign sfrRdata        = st.rdata;
  assign mulClkEn        = st.clkEn;
  assign multiplierReady = st.readyOut;

endmodule

// ==== dv/clock_multiplier_props.sv ====
// Purpose: Port checker for the clock multiplier control block.
// Assumes: One clock domain, synchronous reset.
// Notes:   A shadow copy tracks every accepted control write.
`timescale 1ns/100ps
module clock_multiplier_props (
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic       intOsc,
  input wire logic       extOsc,
  input wire logic [7:0] sfrAddr,
  input wire logic [7:0] sfrPage,
  input wire logic       sfrWrite,
  input wire logic [7:0] sfrWdata,
  input wire logic [7:0] sfrRdata,
  input wire logic       mulClkEn,
  input wire logic       multiplierReady
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic       hit;
  logic [7:0] shadow;
  assign hit = sfrAddr == clock_multiplier_pkg::CTRL_ADDR && sfrPage == clock_multiplier_pkg::CTRL_PAGE;
  always_ff @(posedge clk_sys) begin
    if (rst) shadow <= 8'h00;
    else if (sfrWrite && hit) shadow <= sfrWdata;
  end
  a_readback_value: assert property ($past(hit) |-> sfrRdata[7:6] == $past(shadow[7:6]) &&
    sfrRdata[4:0] == $past(shadow[4:0]) && sfrRdata[5] == $past(multiplierReady)) else $error("readback wrong");
  a_miss_zero: assert property (!$past(hit) |-> sfrRdata == 8'h00) else $error("miss read not zero");
  a_pulse_gap: assert property (mulClkEn |=> !mulClkEn) else $error("pulses adjacent");
  a_quiet_unready: assert property (!multiplierReady [*4] |-> !mulClkEn) else $error("pulse unlocked");
  a_disable_drops: assert property (sfrWrite && hit && !sfrWdata[7] |-> ##2 !multiplierReady)
    else $error("ready kept after disable");
  a_rise_needs_init: assert property ($rose(multiplierReady) |-> $past(shadow[7:6]) == 2'h3)
    else $error("ready without init");
  a_lock_not_instant: assert property (sfrWrite && hit && sfrWdata[7:6] == 2'h3 && !shadow[6] &&
    !multiplierReady |=> !multiplierReady [*8]) else $error("lock too fast");
  a_disabled_quiet: assert property (!shadow[7] [*4] |-> !mulClkEn && !multiplierReady)
    else $error("active while disabled");
  c_locked: cover property ($rose(multiplierReady));
  c_pulse: cover property (mulClkEn ##2 mulClkEn);
  c_drop: cover property (multiplierReady && sfrWrite && hit && !sfrWdata[7]);
endmodule
bind clock_multiplier_control clock_multiplier_props i_clock_multiplier_props (.clk_sys, .rst, .intOsc,
  .extOsc, .sfrAddr, .sfrPage, .sfrWrite, .sfrWdata, .sfrRdata, .mulClkEn, .multiplierReady);

// ==== dv/osc_model.sv ====
// Purpose: Internal and external oscillator sources.
// Assumes: Half periods keep full-rate edges eight clk_sys cycles apart.
// Notes:   The external source stands still at 0 while not running.
`timescale 1ns/100ps
module osc_model #(
  parameter int INT_HALF = 40,
  parameter int EXT_HALF = 60
) (
  input  wire logic extOn,
  output logic      intOsc,
  output logic      extOsc
);
  initial intOsc = 1'b0;
  always #(INT_HALF) intOsc = ~intOsc;
  // The bench runs this source long before any initialize write.
  initial extOsc = 1'b0;
  always #(EXT_HALF) extOsc = extOn & ~extOsc;
endmodule

// ==== dv/clock_multiplier_control_tb_top.sv ====
// Purpose: Self-checking bench for the clock multiplier control block.
// Assumes: Inputs change at the falling edge of clk_sys.
// Notes:   Pulse counts allow a small margin for bursts cut by the window.
`timescale 1ns/100ps
module clock_multiplier_control_tb_top;
  logic       clk_sys = 1'b0, rst = 1'b1, extOn = 1'b1, sfrWrite = 1'b0;
  logic       intOsc, extOsc, mulClkEn, multiplierReady;
  logic [7:0] sfrAddr = 8'h00, sfrPage = 8'h00, sfrWdata = 8'h00, sfrRdata, regv = 8'h00, d;
  logic [1:0] sel = 2'h0;
  int         fail_count, cmp_count, cycles, pulses, edges, expect_n, w;
  always #5 clk_sys = ~clk_sys;
  osc_model i_osc_model (.extOn, .intOsc, .extOsc);
  clock_multiplier_control #(.LOCK_EDGES(2)) i_clock_multiplier_control (.clk_sys, .rst, .intOsc, .extOsc,
    .sfrAddr, .sfrPage, .sfrWrite, .sfrWdata, .sfrRdata, .mulClkEn, .multiplierReady);
  always @(posedge intOsc) if (!sel[0]) edges++;
  always @(posedge extOsc) if (sel[0]) edges++;
  always @(posedge clk_sys) pulses += (mulClkEn === 1'b1);
  task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] p, logic [7:0] v);
    @(negedge clk_sys);
    {sfrAddr, sfrPage, sfrWdata, sfrWrite} = {a, p, v, 1'b1};
    if (a == 8'h97 && p == 8'h0f) regv = v & 8'hdf;
    @(negedge clk_sys);
    sfrWrite = 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] p, logic [7:0] exp);
    @(negedge clk_sys);
    {sfrAddr, sfrPage} = {a, p};
    @(negedge clk_sys);
    check("sfrRdata", sfrRdata, exp);
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    if (++cycles > 30000) begin
      fail_count++;
      wrap_up();
    end
  end
  initial begin
    void'($urandom(13713));
    repeat (16) @(negedge clk_sys);
    rst = 1'b0;
    rd(8'h97, 8'h0f, 8'h00);
    wr(8'h97, 8'h0e, 8'h1f);
    rd(8'h97, 8'h0e, 8'h00);
    rd(8'h97, 8'h0f, 8'h00);
    repeat (20) begin
      d = 8'($urandom) & 8'h7f;
      wr(8'($urandom), 8'h0f, d);
      wr(8'h97, 8'h0f, d);
      rd(8'h97, 8'h0f, regv);
    end
    for (int k = 0; k < 8; k++) begin
      sel = k[1:0];
      wr(8'h97, 8'h0f, 8'h00);
      wr(8'h97, 8'h0f, {6'h0, sel});
      wr(8'h97, 8'h0f, {3'h0, k[2:0], sel});
      wr(8'h97, 8'h0f, regv | 8'h80);
      repeat (520) @(negedge clk_sys);
      rd(8'h97, 8'h0f, regv);
      wr(8'h97, 8'h0f, regv | 8'hc0);
      for (w = 0; w < 500 && multiplierReady !== 1'b1; w++) @(negedge clk_sys);
      rd(8'h97, 8'h0f, regv | 8'h20);
      {pulses, edges} = 0;
      repeat (1500) @(negedge clk_sys);
      expect_n = 4 * (sel[1] ? edges : edges / 2) * (k < 3 ? 1 : 2) / (k < 3 ? 1 : k);
      check("pulse count", {7'h0, pulses >= expect_n - 10 && pulses <= expect_n + 10}, 8'h01);
      wr(8'h97, 8'h0f, 8'h00);
      @(negedge clk_sys);
      check("multiplierReady", {7'h0, multiplierReady}, 8'h00);
    end
    wrap_up();
  end
endmodule
